//--- logic/pbm_port_b_mux.sv
// Port B alternate-function multiplexer: per-pin override of direction,
// output value, pull-up and digital input enable for SPI, timer 0 compare,
// clock output, USART0 clock, external interrupt 2 and pin-change sources.
// Assumes all inputs synchronous to ref_clk; every output is registered.
//
// Notes on behaviour
// - SPI slave forces pin 7 input; as master its direction bit decides.
// - A pin forced to input keeps its pull-up under its output bit.
// - SPI master forces pin 6 input; as slave its direction bit decides.
// - SPI slave forces pin 5 input; as master its direction bit decides.
// - SPI slave forces pin 4 input; slave active while pin 4 held low.
// - Pin 6 carries slave output and master input; pin 5 the reverse.
// - Pin 4 shows timer 0 compare B only with direction bit set.
// - Pin 3 shows timer 0 compare A only with direction bit set.
// - Clock-output fuse drives divided clock on pin 1, also during reset.
// - Pin 0 is USART0 clock only in synchronous mode; direction picks way.
// - Pin 2 feeds external interrupt 2; input kept enabled while it is on.
// - Each pin feeds its pin-change source; input on with mask and group enable.
// - Pull-up override enable selects pull-up from the override value.
// - Direction override enable selects driver from the override value.
// - Value override enable with driver on drives the override value.
// - Input-enable override enable takes input enable from override value.
`timescale 1ns/1ps
`default_nettype none
module pbm_port_b_mux (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [pbm_pkg::PBM_PINS-1:0] pad_in,
   input wire logic [pbm_pkg::PBM_PINS-1:0] direction_bits,
   input wire logic [pbm_pkg::PBM_PINS-1:0] output_bits,
   input wire logic global_pullup_disable,
   input wire logic sleep_input_disable,
   input wire logic spi_enable_bit,
   input wire logic spi_master_select,
   input wire logic spi_sck_out,
   input wire logic spi_master_out,
   input wire logic spi_slave_out,
   input wire logic timer0_compare_out_a,
   input wire logic timer0_compare_a_enable,
   input wire logic timer0_compare_out_b,
   input wire logic timer0_compare_b_enable,
   input wire logic clock_output_fuse,
   input wire logic divided_clock_in,
   input wire logic usart0_sync_mode,
   input wire logic usart0_ext_clock_out,
   input wire logic external_interrupt_2_enable,
   input wire logic pin_change_group1_enable,
   input wire logic [pbm_pkg::PBM_PINS-1:0] pin_change_mask,
   output logic [pbm_pkg::PBM_PINS-1:0] pad_oe,
   output logic [pbm_pkg::PBM_PINS-1:0] pad_out,
   output logic [pbm_pkg::PBM_PINS-1:0] pad_pullup,
   output logic [pbm_pkg::PBM_PINS-1:0] pad_din_en,
   output logic [pbm_pkg::PBM_PINS-1:0] pin_change_source,
   output logic spi_sck_in,
   output logic spi_master_in,
   output logic spi_slave_in,
   output logic spi_select_n,
   output logic external_interrupt_2,
   output logic timer0_count_input,
   output logic timer1_count_input,
   output logic usart0_ext_clock_in
);
   import pbm_pkg::*;

   pbm_state_t st_r;
   pbm_state_t st_nxt;

   logic spi_slave_on;
   logic spi_master_on;
   logic [PBM_PINS-1:0] force_in;
   logic [PBM_PINS-1:0] pu_ovr_val;
   logic [PBM_PINS-1:0] dir_ovr_en;
   logic [PBM_PINS-1:0] dir_ovr_val;
   logic [PBM_PINS-1:0] val_ovr_en;
   logic [PBM_PINS-1:0] val_ovr_val;
   logic [PBM_PINS-1:0] din_ovr_en;
   logic [PBM_PINS-1:0] res_oe;
   logic [PBM_PINS-1:0] res_val;
   logic [PBM_PINS-1:0] res_pull;
   logic [PBM_PINS-1:0] res_die;
   logic [PBM_PINS-1:0] res_din;

   assign spi_slave_on = spi_enable_bit && !spi_master_select;
   assign spi_master_on = spi_enable_bit && spi_master_select;

   always_comb begin
      force_in = '0;
      force_in[PBM_PIN_SCK] = spi_slave_on;
      force_in[PBM_PIN_MSIN] = spi_master_on;
      force_in[PBM_PIN_MSOUT] = spi_slave_on;
      force_in[PBM_PIN_SEL] = spi_slave_on;
      // Forced inputs keep the ordinary output-bit pull-up behaviour
      pu_ovr_val = output_bits & ~{PBM_PINS{global_pullup_disable}};
      dir_ovr_en = force_in;
      dir_ovr_val = '0;
      dir_ovr_en[PBM_PIN_CLK_OUT] = clock_output_fuse;
      dir_ovr_val[PBM_PIN_CLK_OUT] = clock_output_fuse;
      val_ovr_en = '0;
      val_ovr_val = '0;
      val_ovr_en[PBM_PIN_SCK] = spi_master_on;
      val_ovr_val[PBM_PIN_SCK] = spi_sck_out;
      val_ovr_en[PBM_PIN_MSIN] = spi_slave_on;
      val_ovr_val[PBM_PIN_MSIN] = spi_slave_out;
      val_ovr_en[PBM_PIN_MSOUT] = spi_master_on;
      val_ovr_val[PBM_PIN_MSOUT] = spi_master_out;
      val_ovr_en[PBM_PIN_SEL] = timer0_compare_b_enable && direction_bits[PBM_PIN_SEL];
      val_ovr_val[PBM_PIN_SEL] = timer0_compare_out_b;
      val_ovr_en[PBM_PIN_CMPA] = timer0_compare_a_enable && direction_bits[PBM_PIN_CMPA];
      val_ovr_val[PBM_PIN_CMPA] = timer0_compare_out_a;
      val_ovr_en[PBM_PIN_CLK_OUT] = clock_output_fuse;
      val_ovr_val[PBM_PIN_CLK_OUT] = divided_clock_in;
      val_ovr_en[PBM_PIN_XCK] = usart0_sync_mode && direction_bits[PBM_PIN_XCK];
      val_ovr_val[PBM_PIN_XCK] = usart0_ext_clock_out;
      din_ovr_en = pin_change_mask & {PBM_PINS{pin_change_group1_enable}};
      din_ovr_en[PBM_PIN_EXT_INT] = din_ovr_en[PBM_PIN_EXT_INT] || external_interrupt_2_enable;
   end

   for (genvar i = 0; i < PBM_PINS; i++) begin : g_pin
      pbm_pin_ovr u_ovr (
         .dir_bit(direction_bits[i]),
         .out_bit(output_bits[i]),
         .global_pullup_disable(global_pullup_disable),
         .sleep_input_disable(sleep_input_disable),
         .pad_in(pad_in[i]),
         .pullup_override_enable(force_in[i]),
         .pullup_override_value(pu_ovr_val[i]),
         .direction_override_enable(dir_ovr_en[i]),
         .direction_override_value(dir_ovr_val[i]),
         .value_override_enable(val_ovr_en[i]),
         .value_override_value(val_ovr_val[i]),
         .input_enable_override_enable(din_ovr_en[i]),
         .input_enable_override_value(1'h1),
         .oe(res_oe[i]),
         .val(res_val[i]),
         .pull_en(res_pull[i]),
         .din_en(res_die[i]),
         .din(res_din[i])
      );
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.pad_oe = res_oe;
      st_nxt.pad_out = res_val;
      st_nxt.pad_pullup = res_pull;
      st_nxt.pad_din_en = res_die;
      st_nxt.pin_change_source = res_din;
      st_nxt.spi_sck_in = res_din[PBM_PIN_SCK];
      st_nxt.spi_master_in = res_din[PBM_PIN_MSIN];
      st_nxt.spi_slave_in = res_din[PBM_PIN_MSOUT];
      // Select idles high unless a slave SPI sees the pin pulled low
      st_nxt.spi_select_n = spi_slave_on ? res_din[PBM_PIN_SEL] : PBM_SELECT_N_RST;
      st_nxt.external_interrupt_2 = res_din[PBM_PIN_EXT_INT];
      st_nxt.timer1_count_input = res_din[PBM_PIN_CLK_OUT];
      st_nxt.timer0_count_input = res_din[PBM_PIN_XCK];
      st_nxt.usart0_ext_clock_in = usart0_sync_mode && !direction_bits[PBM_PIN_XCK]
         && res_din[PBM_PIN_XCK];
      if (rst) begin
         st_nxt = PBM_STATE_RST;
         // Clock output must keep running through reset
         st_nxt.pad_oe[PBM_PIN_CLK_OUT] = clock_output_fuse;
         st_nxt.pad_out[PBM_PIN_CLK_OUT] = clock_output_fuse && divided_clock_in;
      end
   end

   always_ff @(posedge ref_clk) begin
      st_r <= st_nxt;
   end

   assign pad_oe = st_r.pad_oe;
   assign pad_out = st_r.pad_out;
   assign pad_pullup = st_r.pad_pullup;
   assign pad_din_en = st_r.pad_din_en;
   assign pin_change_source = st_r.pin_change_source;
   assign spi_sck_in = st_r.spi_sck_in;
   assign spi_master_in = st_r.spi_master_in;
   assign spi_slave_in = st_r.spi_slave_in;
   assign spi_select_n = st_r.spi_select_n;
   assign external_interrupt_2 = st_r.external_interrupt_2;
   assign timer0_count_input = st_r.timer0_count_input;
   assign timer1_count_input = st_r.timer1_count_input;
   assign usart0_ext_clock_in = st_r.usart0_ext_clock_in;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   slave_sck_in_a: assert property (spi_slave_on |=> !pad_oe[7])
      else $error("sck pin driven while spi is slave");
   forced_pullup_a: assert property (spi_slave_on |=>
      pad_pullup[5] == $past(output_bits[5] && !global_pullup_disable))
      else $error("forced input pull-up not following output bit");
   master_in_a: assert property (spi_master_on |=> !pad_oe[6])
      else $error("master input pin driven while spi is master");
   slave_mosi_a: assert property (spi_slave_on |=> !pad_oe[5])
      else $error("slave input pin driven while spi is slave");
   slave_select_a: assert property (spi_slave_on |=>
      !pad_oe[4] && spi_select_n == $past(pad_in[4] && res_die[4]))
      else $error("slave select not following pin 4");
   master_route_a: assert property (spi_master_on && direction_bits[5] |=>
      pad_oe[5] && pad_out[5] == $past(spi_master_out))
      else $error("master output not routed to pin 5");
   cmp_b_a: assert property (!spi_slave_on && timer0_compare_b_enable && direction_bits[4]
      |=> pad_oe[4] && pad_out[4] == $past(timer0_compare_out_b))
      else $error("compare b not on pin 4");
   cmp_a_a: assert property (timer0_compare_a_enable && direction_bits[3]
      |=> pad_oe[3] && pad_out[3] == $past(timer0_compare_out_a))
      else $error("compare a not on pin 3");
   clk_out_a: assert property (clock_output_fuse
      |=> pad_oe[1] && pad_out[1] == $past(divided_clock_in))
      else $error("divided clock not on pin 1");
   clk_reset_a: assert property (@(posedge ref_clk) disable iff (1'b0)
      rst && clock_output_fuse |=> pad_oe[1] && pad_out[1] == $past(divided_clock_in))
      else $error("divided clock lost during reset");
   ext_int_en_a: assert property (external_interrupt_2_enable |=> pad_din_en[2])
      else $error("pin 2 input disabled while interrupt 2 enabled");
   pcint_en_a: assert property (pin_change_group1_enable && pin_change_mask[7]
      |=> pad_din_en[7] && pin_change_source[7] == $past(pad_in[7]))
      else $error("pin change source 15 not fed");

   slave_cov_c: cover property (spi_slave_on ##1 !spi_select_n);
   master_cov_c: cover property (spi_master_on && direction_bits[7] ##1 pad_oe[7]);
   clk_cov_c: cover property (clock_output_fuse ##1 pad_out[1] ##1 !pad_out[1]);
   xck_cov_c: cover property (usart0_sync_mode && !direction_bits[0] ##1 usart0_ext_clock_in);
endmodule
`default_nettype wire

//--- common/pbm_pkg.sv
// Shared constants and state type of the port B alternate-function multiplexer.
// Assumes a single clock domain and a synchronous, active-high reset.
`default_nettype none
package pbm_pkg;
   localparam int PBM_PINS = 8;

   // Pin positions of the alternate functions
   localparam int PBM_PIN_SCK = 7;
   localparam int PBM_PIN_MSIN = 6;
   localparam int PBM_PIN_MSOUT = 5;
   localparam int PBM_PIN_SEL = 4;
   localparam int PBM_PIN_CMPA = 3;
   localparam int PBM_PIN_EXT_INT = 2;
   localparam int PBM_PIN_CLK_OUT = 1;
   localparam int PBM_PIN_XCK = 0;

   typedef struct packed {
      logic [PBM_PINS-1:0] pad_oe;
      logic [PBM_PINS-1:0] pad_out;
      logic [PBM_PINS-1:0] pad_pullup;
      logic [PBM_PINS-1:0] pad_din_en;
      logic [PBM_PINS-1:0] pin_change_source;
      logic spi_sck_in;
      logic spi_master_in;
      logic spi_slave_in;
      logic spi_select_n;
      logic external_interrupt_2;
      logic timer0_count_input;
      logic timer1_count_input;
      logic usart0_ext_clock_in;
   } pbm_state_t;

   // Values after reset: every pad released except pin 1 under the clock-output fuse, select inactive (high)
   localparam logic [PBM_PINS-1:0] PBM_PAD_OE_RST = 8'h00;
   localparam logic [PBM_PINS-1:0] PBM_PAD_OUT_RST = 8'h00;
   localparam logic [PBM_PINS-1:0] PBM_PULLUP_RST = 8'h00;
   localparam logic [PBM_PINS-1:0] PBM_DIN_EN_RST = 8'h00;
   localparam logic [PBM_PINS-1:0] PBM_PCINT_RST = 8'h00;
   localparam logic PBM_SELECT_N_RST = 1'b1;

   localparam pbm_state_t PBM_STATE_RST = '{
      pad_oe: PBM_PAD_OE_RST,
      pad_out: PBM_PAD_OUT_RST,
      pad_pullup: PBM_PULLUP_RST,
      pad_din_en: PBM_DIN_EN_RST,
      pin_change_source: PBM_PCINT_RST,
      spi_sck_in: 1'b0,
      spi_master_in: 1'b0,
      spi_slave_in: 1'b0,
      spi_select_n: PBM_SELECT_N_RST,
      external_interrupt_2: 1'b0,
      timer0_count_input: 1'b0,
      timer1_count_input: 1'b0,
      usart0_ext_clock_in: 1'b0
   };
endpackage
`default_nettype wire

//--- logic/pbm_pin_ovr.sv
// Override resolver for one port pin: merges plain port bits with the
// alternate-function override signals into driver, value, pull-up and input enable.
// Purely combinational; the instantiating module registers the results.
`timescale 1ns/1ps
`default_nettype none
module pbm_pin_ovr (
   input wire logic dir_bit,
   input wire logic out_bit,
   input wire logic global_pullup_disable,
   input wire logic sleep_input_disable,
   input wire logic pad_in,
   input wire logic pullup_override_enable,
   input wire logic pullup_override_value,
   input wire logic direction_override_enable,
   input wire logic direction_override_value,
   input wire logic value_override_enable,
   input wire logic value_override_value,
   input wire logic input_enable_override_enable,
   input wire logic input_enable_override_value,
   output logic oe,
   output logic val,
   output logic pull_en,
   output logic din_en,
   output logic din
);
   always_comb begin
      oe = direction_override_enable ? direction_override_value : dir_bit;
      val = value_override_enable ? value_override_value : out_bit;
      // Pull-up only on an undriven pin, so a driven high never fights it
      if (pullup_override_enable) begin
         pull_en = pullup_override_value;
      end else begin
         pull_en = !oe && out_bit && !global_pullup_disable;
      end
      if (input_enable_override_enable) begin
         din_en = input_enable_override_value;
      end else begin
         din_en = !sleep_input_disable;
      end
      din = pad_in && din_en;
   end
endmodule
`default_nettype wire

//--- sim/pbm_periph_model.sv
// Behavioural far side of the port B mux: SPI, timer 0 compare, divided clock
// and USART0 clock sources. Levels move on the falling edge of ref_clk so the
// mux always samples settled values on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module pbm_periph_model (
   input wire logic ref_clk,
   output logic spi_sck_out,
   output logic spi_master_out,
   output logic spi_slave_out,
   output logic timer0_compare_out_a,
   output logic timer0_compare_out_b,
   output logic divided_clock_in,
   output logic usart0_ext_clock_out
);
   logic [3:0] cnt_r = 4'h0;

   // Free-running pattern so a stuck or swapped route shows up within a few cycles
   always @(negedge ref_clk) begin
      cnt_r <= cnt_r + 4'h1;
   end

   assign spi_sck_out = cnt_r[0];
   assign spi_master_out = cnt_r[1];
   assign spi_slave_out = cnt_r[2];
   assign timer0_compare_out_a = cnt_r[1] ^ cnt_r[3];
   assign timer0_compare_out_b = cnt_r[2] ^ cnt_r[0];
   // Divided system clock keeps running through reset
   assign divided_clock_in = cnt_r[1];
   assign usart0_ext_clock_out = cnt_r[0];
endmodule
`default_nettype wire

//--- sim/pbm_port_b_mux_tb.sv
// Self-checking bench for the port B alternate-function mux.
// Assumes outputs are registered one ref_clk cycle after the inputs.
`timescale 1ns/1ps
`default_nettype none
module pbm_port_b_mux_tb;
   import pbm_pkg::*;
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] pad_in = 8'hff, dir = 8'h00, outb = 8'h00, mask = 8'h00;
   logic pu_dis = 1'h0, sleep = 1'h0, spi_en = 1'h0, spi_mst = 1'h0, ca_en = 1'h0, cb_en = 1'h0;
   logic fuse = 1'h0, sync = 1'h0, ext_int_en = 1'h0, pcie = 1'h0;
   logic sck_o, mo, so, ca, cb, dclk, uclk;
   logic [7:0] oe, po, pu, die, pcs;
   logic sck_i, mi, si, ssn, ext_int, tmr0_in, tmr1_in, uin;
   logic [6:0] pq;
   int mismatches = 0;
   int num_checks = 0;

   always #25 ref_clk = ~ref_clk;

   // Far-side levels as the mux saw them at the last rising edge
   always @(posedge ref_clk) pq <= {uclk, dclk, cb, ca, so, mo, sck_o};

   pbm_periph_model per (.ref_clk(ref_clk), .spi_sck_out(sck_o), .spi_master_out(mo),
      .spi_slave_out(so), .timer0_compare_out_a(ca), .timer0_compare_out_b(cb),
      .divided_clock_in(dclk), .usart0_ext_clock_out(uclk));

   pbm_port_b_mux dut (.ref_clk(ref_clk), .rst(rst), .pad_in(pad_in), .direction_bits(dir),
      .output_bits(outb), .global_pullup_disable(pu_dis), .sleep_input_disable(sleep),
      .spi_enable_bit(spi_en), .spi_master_select(spi_mst), .spi_sck_out(sck_o),
      .spi_master_out(mo), .spi_slave_out(so), .timer0_compare_out_a(ca),
      .timer0_compare_a_enable(ca_en), .timer0_compare_out_b(cb),
      .timer0_compare_b_enable(cb_en), .clock_output_fuse(fuse), .divided_clock_in(dclk),
      .usart0_sync_mode(sync), .usart0_ext_clock_out(uclk),
      .external_interrupt_2_enable(ext_int_en), .pin_change_group1_enable(pcie),
      .pin_change_mask(mask), .pad_oe(oe), .pad_out(po), .pad_pullup(pu), .pad_din_en(die),
      .pin_change_source(pcs), .spi_sck_in(sck_i), .spi_master_in(mi), .spi_slave_in(si),
      .spi_select_n(ssn), .external_interrupt_2(ext_int), .timer0_count_input(tmr0_in),
      .timer1_count_input(tmr1_in), .usart0_ext_clock_in(uin));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic step();
      @(negedge ref_clk);
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic t_plain();
      dir = 8'h0f;
      outb = 8'h5a;
      step();
      chk(oe, 8'h0f);
      chk(po & oe, 8'h0a);
      chk(pu, 8'h50);
      chk(die, 8'hff);
      pu_dis = 1'h1;
      step();
      chk(pu, 8'h00);
      pu_dis = 1'h0;
      $display("test plain finished");
   endtask

   task automatic t_slave();
      spi_en = 1'h1;
      dir = 8'hff;
      outb = 8'hff;
      pad_in = 8'hef;
      step();
      chk(oe, 8'h4f);
      chk(po[6], pq[2]);
      chk(pu, 8'hb0);
      chk(ssn, 1'h0);
      chk(si, 1'h1);
      chk(sck_i, 1'h1);
      pad_in = 8'hff;
      pu_dis = 1'h1;
      dir = 8'h00;
      step();
      chk(ssn, 1'h1);
      chk(pu, 8'h00);
      chk(oe, 8'h00);
      $display("test slave finished");
   endtask

   task automatic t_master();
      spi_mst = 1'h1;
      dir = 8'hff;
      pu_dis = 1'h0;
      pad_in = 8'h40;
      step();
      chk(oe, 8'hbf);
      chk(po[7], pq[0]);
      chk(po[5], pq[1]);
      chk(mi, 1'h1);
      chk(ssn, 1'h1);
      chk(pu, 8'h40);
      dir = 8'h00;
      step();
      chk(oe, 8'h00);
      spi_en = 1'h0;
      spi_mst = 1'h0;
      $display("test master finished");
   endtask

   task automatic t_compare();
      ca_en = 1'h1;
      cb_en = 1'h1;
      dir = 8'h18;
      outb = 8'h00;
      repeat (3) begin
         step();
         chk(po[4], pq[4]);
         chk(po[3], pq[3]);
         chk(oe, 8'h18);
      end
      dir = 8'h00;
      step();
      chk(oe, 8'h00);
      ca_en = 1'h0;
      cb_en = 1'h0;
      dir = 8'h18;
      outb = 8'h18;
      step();
      chk(po & 8'h18, 8'h18);
      cb_en = 1'h1;
      spi_en = 1'h1;
      step();
      chk(oe & 8'h10, 8'h00);
      spi_en = 1'h0;
      cb_en = 1'h0;
      dir = 8'h00;
      outb = 8'h00;
      $display("test compare finished");
   endtask

   task automatic t_clock();
      fuse = 1'h1;
      repeat (4) begin
         step();
         chk(oe, 8'h02);
         chk(po[1], pq[5]);
      end
      rst = 1'h1;
      repeat (2) begin
         step();
         chk(oe, 8'h02);
         chk(po[1], pq[5]);
      end
      rst = 1'h0;
      fuse = 1'h0;
      step();
      chk(oe, 8'h00);
      $display("test clock finished");
   endtask

   task automatic t_usart();
      sync = 1'h1;
      dir = 8'h01;
      repeat (2) begin
         step();
         chk(oe, 8'h01);
         chk(po[0], pq[6]);
      end
      dir = 8'h00;
      pad_in = 8'h01;
      step();
      chk(uin, 1'h1);
      sync = 1'h0;
      dir = 8'h01;
      repeat (2) begin
         step();
         chk(uin, 1'h0);
         chk(po[0], 1'h0);
      end
      dir = 8'h00;
      $display("test usart finished");
   endtask

   task automatic t_inputs();
      sleep = 1'h1;
      pad_in = 8'hff;
      step();
      chk(die, 8'h00);
      chk(pcs, 8'h00);
      chk(ext_int, 1'h0);
      ext_int_en = 1'h1;
      step();
      chk(die, 8'h04);
      chk(ext_int, 1'h1);
      ext_int_en = 1'h0;
      pcie = 1'h1;
      mask = 8'ha3;
      step();
      chk(die, 8'ha3);
      chk(pcs, 8'ha3);
      chk(tmr1_in, 1'h1);
      chk(tmr0_in, 1'h1);
      pcie = 1'h0;
      step();
      chk(die, 8'h00);
      sleep = 1'h0;
      $display("test inputs finished");
   endtask

   initial begin
      #(400 * 50);
      mismatches++;
      end_of_test();
   end

   initial begin
      repeat (10) @(negedge ref_clk);
      rst = 1'h0;
      t_plain();
      t_slave();
      t_master();
      t_compare();
      t_clock();
      t_usart();
      t_inputs();
      end_of_test();
   end
endmodule
`default_nettype wire
